// ---- common/stream_ctrl_defines.vh ----
// Constants for the stream, tick counter and configuration set control block.
// Assumes a 250 MHz system clock and a plain strobe register port.
`ifndef STREAM_CTRL_DEFINES_VH
`define STREAM_CTRL_DEFINES_VH

`define ADDR_DEST_PORT     8'h00
`define ADDR_STREAM_CFG    8'h04
`define ADDR_IPD           8'h08
`define ADDR_DEST_IP       8'h0C
`define ADDR_PKT_BYTES     8'h10
`define ADDR_TICK_RATE_LO  8'h14
`define ADDR_TICK_RATE_HI  8'h18
`define ADDR_TICK_CMD      8'h1C
`define ADDR_SNAP_LO       8'h20
`define ADDR_SNAP_HI       8'h24
`define ADDR_SET_SELECT    8'h28
`define ADDR_SET_CMD       8'h2C
`define ADDR_SET_STARTUP   8'h30
`define ADDR_STATUS        8'h34

`define CFG_TEST_BIT       0
`define CFG_NOFRAG_BIT     1
`define CMD_SNAP_BIT       0
`define CMD_CLEAR_BIT      1
`define CMD_RESTORE_BIT    0
`define CMD_STORE_BIT      1

`define PKT_BYTES_MIN      16'h0048
`define PKT_BYTES_MAX      16'h1FE4
`define PKT_BYTES_RESET    16'h05DC
`define DEST_PORT_RESET    16'h0000
`define IPD_RESET          32'h0000_0000
`define DEST_IP_RESET      32'h0000_0000
`define SET_FACTORY        3'h0
`define SET_LAST           3'h4
`define TICK_RATE_RESET    64'h0000_0000_0EE6_B280

`endif

// ---- testbench/pkt_sender_model.sv ----
// Packet sender model: takes payload words, signals packet end.
// Assumes one tx_start pulse per packet and tx_bytes held meanwhile.
module pkt_sender_model (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        hold,
	input  wire        tx_start,
	input  wire        tx_test,
	input  wire        tx_valid,
	input  wire [15:0] tx_bytes,
	output reg         tx_ready,
	output reg         tx_done,
	output reg  [15:0] pkts,
	output reg  [15:0] tests,
	output reg  [15:0] words
);
	reg        active;
	reg [15:0] cnt;
	reg [3:0]  idle;
	wire       take = tx_valid && tx_ready;
	integer    seed = 7;
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			{active, cnt, idle, tx_ready, tx_done, pkts, tests, words} <= 0;
		end else begin
			tx_done <= 1'b0;
			// Mixes prompt and slow acceptance
			tx_ready <= !hold && ($random(seed) % 4 != 0);
			if (tx_start) begin
				active <= 1'b1;
				cnt <= 16'h0000;
				idle <= 4'h0;
				pkts <= pkts + {15'h0000, !tx_test};
				tests <= tests + {15'h0000, tx_test};
			end else if (active) begin
				idle <= tx_valid ? 4'h0 : idle + 4'h1;
				cnt <= cnt + {15'h0000, take};
				words <= words + {15'h0000, take};
				// Short final packet only ends by silence
				if ((cnt + take) * 4 >= tx_bytes || &idle) begin
					active <= 1'b0;
					tx_done <= 1'b1;
				end
			end
		end
	end
endmodule // pkt_sender_model

// ---- testbench/stream_ctrl_properties.sv ----
// Port checks for the stream control block, bound to every instance.
// Assumes clk_en only falls while the block sits idle with nothing to show.
module stream_ctrl_checker (
	input wire        sys_clk,
	input wire        rst_b,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire        tx_start,
	input wire        tx_busy,
	input wire [15:0] tx_bytes,
	input wire        tx_valid,
	input wire        tx_ready,
	input wire [31:0] tx_data,
	input wire [15:0] stream_dest_port,
	input wire [31:0] stream_dest_ip,
	input wire        stream_no_fragment_flag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 32'h0000_0000; endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data off cycle");
	property p_start_pulse; tx_start |=> !tx_start; endproperty
	a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
	property p_start_busy; tx_start |-> tx_busy; endproperty
	a_start_busy: assert property (p_start_busy) else $error("start without busy");
	property p_no_start_busy; tx_start |-> !$past(tx_busy); endproperty
	a_no_start_busy: assert property (p_no_start_busy) else $error("start while busy");
	property p_bytes; tx_start |-> tx_bytes >= 16'h0048 && tx_bytes <= 16'h1FE4; endproperty
	a_bytes: assert property (p_bytes) else $error("packet size out of range");
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
	a_hold: assert property (p_hold) else $error("word dropped under stall");
	property p_busy_valid; tx_valid |-> tx_busy; endproperty
	a_busy_valid: assert property (p_busy_valid) else $error("word outside packet");
	property p_reset_set;
		$rose(rst_b) |-> stream_dest_port == 16'h0000 && stream_dest_ip == 32'h0000_0000
			&& !stream_no_fragment_flag;
	endproperty
	a_reset_set: assert property (p_reset_set) else $error("settings not at reset");
endmodule // stream_ctrl_checker

bind stream_ctrl stream_ctrl_checker u_chk (.*);

// ---- testbench/tb_stream_ctrl.sv ----
// Self-checking bench for the stream control block.
// Assumes the sender model on the packet side and the bound checker.
`include "stream_ctrl_defines.vh"
module tb_stream_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	reg         sys_clk, rst_b, reg_wr, reg_rd, tick, pix_valid, pix_last, hold, gap_on, clk_en;
	reg  [7:0]  reg_addr;
	reg  [31:0] reg_wdata, pix_data, rv, v2, xs, xr;
	reg  [15:0] bp, bw, bt;
	wire [31:0] reg_rdata, tx_data, dest_ip;
	wire [15:0] tx_bytes, dest_port, pkts, tests, words;
	wire        pix_ready, tx_valid, tx_ready, tx_start, tx_test, nofrag, tx_done, tx_busy;
	integer     seed = 23, error_cnt = 0, checks_done = 0, i, n, gap_n, gap_d = 3;
	initial begin
		sys_clk = 0;
		forever #2 sys_clk = ~sys_clk;
	end
	stream_ctrl #(.TICK_RATE(64'h0000_0001_2345_6789)) dut_u (.sys_clk(sys_clk),
		.rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick(tick),
		.pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready),
		.pix_last(pix_last), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_start(tx_start), .tx_test(tx_test), .tx_bytes(tx_bytes),
		.stream_dest_port(dest_port), .stream_dest_ip(dest_ip),
		.stream_no_fragment_flag(nofrag), .tx_done(tx_done), .tx_busy(tx_busy));
	pkt_sender_model u_sender (.sys_clk(sys_clk), .rst_b(rst_b), .hold(hold),
		.tx_start(tx_start), .tx_test(tx_test), .tx_valid(tx_valid), .tx_bytes(tx_bytes),
		.tx_ready(tx_ready), .tx_done(tx_done), .pkts(pkts), .tests(tests), .words(words));
	task print_verdict;
		begin
			$display("checks %0d errors %0d", checks_done, error_cnt);
			if (error_cnt == 0 && checks_done > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] s);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED %s exp %h got %h", nm, e, s);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge sys_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [7:0] a, output [31:0] d);
		begin
			@(posedge sys_clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge sys_clk);
			reg_rd <= 1'b0;
			#1 d = reg_rdata;
		end
	endtask
	task rc(input [7:0] a, input [31:0] e);
		begin
			rd(a, v2);
			chk($sformatf("reg_%h", a), e, v2);
		end
	endtask
	task push(input [31:0] d, input l);
		begin
			pix_valid <= 1'b1;
			pix_data <= d;
			pix_last <= l;
			n = 0;
			do begin
				@(posedge sys_clk);
				n = n + 1;
			end while (!pix_ready && n < 100);
			if (n == 100) chk("push", 1, 0);
			if (pix_ready) xs = xs ^ d;
		end
	endtask
	// Needs a long quiet spell so a refiring packet is not missed
	task settle;
		begin
			n = 0;
			for (i = 0; i < 3000 && n < 40; i = i + 1) begin
				@(posedge sys_clk);
				n = (tx_busy || pix_valid) ? 0 : n + 1;
			end
			if (n < 40) begin
				chk("settle", 1, 0);
				print_verdict;
			end
		end
	endtask
	function [31:0] clamp(input [31:0] x);
		clamp = x < `PKT_BYTES_MIN ? `PKT_BYTES_MIN : x > `PKT_BYTES_MAX ? `PKT_BYTES_MAX : x;
	endfunction
	always @(posedge sys_clk) begin
		tick <= $random(seed) & 1;
		if (!rst_b)
			xr <= 32'h0000_0000;
		else if (tx_valid && tx_ready)
			xr <= xr ^ tx_data;
		if (tx_done) begin
			gap_on <= 1'b1;
			gap_n <= 0;
		end else if (gap_on && !tx_busy) begin
			gap_on <= 1'b0;
			chk("gap_ticks", 1, gap_n + 1 >= gap_d && gap_n <= gap_d + 1);
		end else if (gap_on && tick) begin
			gap_n <= gap_n + 1;
		end
	end
	initial begin
		{rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, pix_valid, pix_last} = 0;
		{pix_data, hold, tick, gap_on, xs} = 0;
		clk_en = 1'b1;
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rc(`ADDR_PKT_BYTES, 32'h0000_05DC);
		rc(`ADDR_TICK_RATE_LO, 32'h2345_6789);
		rc(`ADDR_TICK_RATE_HI, 32'h0000_0001);
		rc(8'hFC, 32'h0000_0000);
		for (i = 0; i < 4; i = i + 1) begin
			rv = $random(seed);
			wr(`ADDR_DEST_PORT, rv);
			wr(`ADDR_DEST_IP, ~rv);
			wr(`ADDR_STREAM_CFG, {30'h0000_0000, rv[0], 1'b0});
			@(posedge sys_clk);
			chk("dest_port", {16'h0000, rv[15:0]}, {16'h0000, dest_port});
			chk("dest_ip", ~rv, dest_ip);
			chk("nofrag", {31'h0000_0000, rv[0]}, {31'h0000_0000, nofrag});
		end
		for (i = 0; i < 6; i = i + 1) begin
			rv = i < 2 ? 71 + i : i < 4 ? 8162 + i : $random(seed) & 32'h0000_FFFF;
			wr(`ADDR_PKT_BYTES, rv);
			rc(`ADDR_PKT_BYTES, clamp(rv));
		end
		wr(`ADDR_PKT_BYTES, 32'h0000_0048);
		wr(`ADDR_IPD, 32'h0000_0003);
		bt = tests;
		wr(`ADDR_STREAM_CFG, 32'h0000_0001);
		settle;
		chk("test_pkts", bt + 1, tests);
		rc(`ADDR_STREAM_CFG, 32'h0000_0000);
		bp = pkts;
		bw = words;
		for (i = 0; i < 20; i = i + 1) push($random(seed), i == 19);
		pix_valid <= 1'b0;
		settle;
		chk("data_pkts", bp + 2, pkts);
		chk("data_words", bw + 20, words);
		chk("data_xor", xs, xr);
		hold <= 1'b1;
		pix_valid <= 1'b1;
		for (n = 0; n < 40 && pix_ready; n = n + 1) @(posedge sys_clk);
		chk("fifo_fills", 1, n >= 16 && n < 40);
		hold <= 1'b0;
		push(0, 1);
		pix_valid <= 1'b0;
		settle;
		chk("fifo_drains", 1, pix_ready);
		wr(`ADDR_TICK_CMD, 32'h0000_0002);
		wr(`ADDR_TICK_CMD, 32'h0000_0001);
		rc(`ADDR_SNAP_HI, 32'h0000_0000);
		rd(`ADDR_SNAP_LO, rv);
		chk("snap_small", 1, rv < 8);
		repeat (30) @(posedge sys_clk);
		rc(`ADDR_SNAP_LO, rv);
		rc(`ADDR_TICK_CMD, 32'h0000_0000);
		wr(`ADDR_TICK_CMD, 32'h0000_0001);
		rd(`ADDR_SNAP_LO, v2);
		chk("snap_grows", 1, v2 > rv);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wr(`ADDR_IPD, 32'h0000_0005);
		clk_en <= 1'b1;
		rc(`ADDR_IPD, 32'h0000_0003);
		for (i = 1; i <= 4; i = i + 1) begin
			wr(`ADDR_SET_SELECT, i);
			wr(`ADDR_DEST_PORT, 32'h0000_1000 + i);
			wr(`ADDR_SET_CMD, 32'h0000_0002);
		end
		wr(`ADDR_SET_SELECT, 32'h0000_0005);
		rc(`ADDR_SET_SELECT, 32'h0000_0004);
		wr(`ADDR_SET_SELECT, 32'h0000_0000);
		wr(`ADDR_SET_CMD, 32'h0000_0002);
		rc(`ADDR_STATUS, 32'h0000_0004);
		wr(`ADDR_SET_CMD, 32'h0000_0001);
		rc(`ADDR_DEST_PORT, 32'h0000_0000);
		wr(`ADDR_SET_STARTUP, 32'h0000_0002);
		rc(`ADDR_SET_STARTUP, 32'h0000_0002);
		rst_b <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		rc(`ADDR_DEST_PORT, 32'h0000_1002);
		rc(`ADDR_SET_STARTUP, 32'h0000_0002);
		for (i = 4; i >= 1; i = i - 1) begin
			wr(`ADDR_SET_SELECT, i);
			wr(`ADDR_SET_CMD, 32'h0000_0001);
			rc(`ADDR_DEST_PORT, 32'h0000_1000 + i);
		end
		print_verdict;
	end
endmodule // tb_stream_ctrl

// ---- verilog/stream_ctrl.v ----
// Stream channel control, tick counter and configuration set storage.
// Assumes a strobe register port and a downstream packet sender that
// reports packet end; payload words arrive from the image pipeline.
`include "stream_ctrl_defines.vh"
module stream_ctrl #(
	parameter        FIFO_DEPTH = 16,
	parameter        FIFO_AW    = 4,
	parameter [63:0] TICK_RATE  = `TICK_RATE_RESET
) (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire        clk_en,
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	input  wire        tick,
	input  wire [31:0] pix_data,
	input  wire        pix_valid,
	output reg         pix_ready,
	input  wire        pix_last,
	output reg  [31:0] tx_data,
	output reg         tx_valid,
	input  wire        tx_ready,
	output reg         tx_start,
	output reg         tx_test,
	output reg  [15:0] tx_bytes,
	output reg  [15:0] stream_dest_port,
	output reg  [31:0] stream_dest_ip,
	output reg         stream_no_fragment_flag,
	input  wire        tx_done,
	output reg         tx_busy
);
	localparam ST_IDLE = 2'd0;
	localparam ST_SEND = 2'd1;
	localparam ST_WAIT = 2'd2;
	localparam ST_GAP  = 2'd3;
	localparam [FIFO_AW:0] FILL_MAX = FIFO_DEPTH[FIFO_AW:0];

	// Working settings
	reg [31:0] stream_interpacket_delay;
	reg [15:0] stream_packet_bytes;
	reg [2:0]  config_set_select;
	reg [2:0]  config_set_startup;
	reg [63:0] tick_count;
	reg [63:0] tick_counter_snapshot;
	reg        test_pending;
	reg        store_rejected;
	reg        boot_load;
	// Stored user sets; index 0 is the factory image and is never written
	reg [15:0] nv_port  [0:4];
	reg [31:0] nv_ip    [0:4];
	reg [31:0] nv_ipd   [0:4];
	reg [15:0] nv_bytes [0:4];
	reg        nv_nofrag[0:4];
	reg [1:0]  state;
	reg [31:0] gap_count;
	reg [15:0] sent_bytes;
	reg  [FIFO_AW:0] fill;
	wire [FIFO_AW:0] next_fill;
	wire [32:0] f_data;
	wire        f_valid;
	wire        f_push;
	wire        f_pop;
	wire        f_take;

	function [15:0] clamp_bytes;
		input [15:0] v;
		begin
			if (v < `PKT_BYTES_MIN)
				clamp_bytes = `PKT_BYTES_MIN;
			else if (v > `PKT_BYTES_MAX)
				clamp_bytes = `PKT_BYTES_MAX;
			else
				clamp_bytes = v;
		end
	endfunction

	function hit;
		input [7:0] a;
		input [7:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	stream_word_fifo #(
		.WIDTH(33),
		.DEPTH(FIFO_DEPTH),
		.AW   (FIFO_AW)
	) u_fifo (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.in_data  ({pix_last, pix_data}),
		.in_valid (f_push),
		.in_ready (),
		.out_data (f_data),
		.out_valid(f_valid),
		.out_ready(f_take)
	);

	// Pops only while the sender is inside a packet and not back-pressured
	assign f_take = (state == ST_SEND) && (!tx_valid || tx_ready);
	// Ready is registered, so it comes from the fill level after this edge;
	// a word only counts as handed over while the source sees ready high
	assign f_push    = pix_valid & pix_ready;
	assign f_pop     = f_take & f_valid;
	assign next_fill = fill + {{FIFO_AW{1'b0}}, f_push} - {{FIFO_AW{1'b0}}, f_pop};

	always @(posedge sys_clk) begin
		if (clk_en && reg_wr && hit(reg_addr, `ADDR_SET_CMD) && reg_wdata[`CMD_STORE_BIT]
		    && config_set_select != `SET_FACTORY && config_set_select <= `SET_LAST) begin
			nv_port[config_set_select]   <= stream_dest_port;
			nv_ip[config_set_select]     <= stream_dest_ip;
			nv_ipd[config_set_select]    <= stream_interpacket_delay;
			nv_bytes[config_set_select]  <= stream_packet_bytes;
			nv_nofrag[config_set_select] <= stream_no_fragment_flag;
		end
	end

	// Startup choice lives with the stored sets, so a reset does not lose it
	always @(posedge sys_clk) begin
		if (clk_en && reg_wr && hit(reg_addr, `ADDR_SET_STARTUP) && reg_wdata[2:0] <= `SET_LAST)
			config_set_startup <= reg_wdata[2:0];
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stream_dest_port         <= `DEST_PORT_RESET;
			stream_dest_ip           <= `DEST_IP_RESET;
			stream_interpacket_delay <= `IPD_RESET;
			stream_packet_bytes      <= `PKT_BYTES_RESET;
			stream_no_fragment_flag  <= 1'b0;
			config_set_select        <= `SET_FACTORY;
			tick_count               <= 64'h0000_0000_0000_0000;
			tick_counter_snapshot    <= 64'h0000_0000_0000_0000;
			test_pending             <= 1'b0;
			store_rejected           <= 1'b0;
			boot_load                <= 1'b1;
			reg_rdata                <= 32'h0000_0000;
		end else if (clk_en) begin
			if (tick)
				tick_count <= tick_count + 64'h0000_0000_0000_0001;
			if (boot_load) begin
				boot_load <= 1'b0;
				if (config_set_startup != `SET_FACTORY && config_set_startup <= `SET_LAST) begin
					stream_dest_port         <= nv_port[config_set_startup];
					stream_dest_ip           <= nv_ip[config_set_startup];
					stream_interpacket_delay <= nv_ipd[config_set_startup];
					stream_packet_bytes      <= nv_bytes[config_set_startup];
					stream_no_fragment_flag  <= nv_nofrag[config_set_startup];
				end
			end
			if (state == ST_IDLE && test_pending && !f_valid)
				test_pending <= 1'b0;
			if (reg_wr) begin
				case (reg_addr)
				`ADDR_DEST_PORT: stream_dest_port <= reg_wdata[15:0];
				`ADDR_STREAM_CFG: begin
					stream_no_fragment_flag <= reg_wdata[`CFG_NOFRAG_BIT];
					if (reg_wdata[`CFG_TEST_BIT])
						test_pending <= 1'b1;
				end
				`ADDR_IPD: stream_interpacket_delay <= reg_wdata;
				`ADDR_DEST_IP: stream_dest_ip <= reg_wdata;
				`ADDR_PKT_BYTES: stream_packet_bytes <= clamp_bytes(reg_wdata[15:0]);
				`ADDR_TICK_CMD: begin
					if (reg_wdata[`CMD_SNAP_BIT])
						tick_counter_snapshot <= tick_count;
					if (reg_wdata[`CMD_CLEAR_BIT])
						tick_count <= 64'h0000_0000_0000_0000;
				end
				`ADDR_SET_SELECT: if (reg_wdata[2:0] <= `SET_LAST)
					config_set_select <= reg_wdata[2:0];
				`ADDR_SET_CMD: begin
					if (reg_wdata[`CMD_STORE_BIT])
						store_rejected <= (config_set_select == `SET_FACTORY);
					if (reg_wdata[`CMD_RESTORE_BIT] && config_set_select != `SET_FACTORY) begin
						stream_dest_port         <= nv_port[config_set_select];
						stream_dest_ip           <= nv_ip[config_set_select];
						stream_interpacket_delay <= nv_ipd[config_set_select];
						stream_packet_bytes      <= nv_bytes[config_set_select];
						stream_no_fragment_flag  <= nv_nofrag[config_set_select];
					end else if (reg_wdata[`CMD_RESTORE_BIT]) begin
						stream_dest_port         <= `DEST_PORT_RESET;
						stream_dest_ip           <= `DEST_IP_RESET;
						stream_interpacket_delay <= `IPD_RESET;
						stream_packet_bytes      <= `PKT_BYTES_RESET;
						stream_no_fragment_flag  <= 1'b0;
					end
				end
				default: ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
				`ADDR_DEST_PORT:    reg_rdata <= {16'h0000, stream_dest_port};
				`ADDR_STREAM_CFG:   reg_rdata <= {30'h0, stream_no_fragment_flag, test_pending};
				`ADDR_IPD:          reg_rdata <= stream_interpacket_delay;
				`ADDR_DEST_IP:      reg_rdata <= stream_dest_ip;
				`ADDR_PKT_BYTES:    reg_rdata <= {16'h0000, stream_packet_bytes};
				`ADDR_TICK_RATE_LO: reg_rdata <= TICK_RATE[31:0];
				`ADDR_TICK_RATE_HI: reg_rdata <= TICK_RATE[63:32];
				`ADDR_SNAP_LO:      reg_rdata <= tick_counter_snapshot[31:0];
				`ADDR_SNAP_HI:      reg_rdata <= tick_counter_snapshot[63:32];
				`ADDR_SET_SELECT:   reg_rdata <= {29'h0, config_set_select};
				`ADDR_SET_STARTUP:  reg_rdata <= {29'h0, config_set_startup};
				`ADDR_STATUS:       reg_rdata <= {29'h0, store_rejected, test_pending, tx_busy};
				default:            reg_rdata <= 32'h0000_0000;
				endcase
			end else begin
				reg_rdata <= 32'h0000_0000;
			end
		end
	end

	// Packet sequencer; the gap counts ticks only after the sender signals packet end
	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state      <= ST_IDLE;
			gap_count  <= 32'h0000_0000;
			sent_bytes <= 16'h0000;
			tx_data    <= 32'h0000_0000;
			tx_valid   <= 1'b0;
			tx_start   <= 1'b0;
			tx_test    <= 1'b0;
			tx_bytes   <= 16'h0000;
			tx_busy    <= 1'b0;
			pix_ready  <= 1'b0;
			fill       <= {(FIFO_AW+1){1'b0}};
		end else if (clk_en) begin
			tx_start  <= 1'b0;
			fill      <= next_fill;
			pix_ready <= (next_fill < FILL_MAX);
			if (tx_valid && tx_ready)
				tx_valid <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (f_valid) begin
					tx_start   <= 1'b1;
					tx_test    <= 1'b0;
					tx_bytes   <= stream_packet_bytes;
					sent_bytes <= 16'h0000;
					tx_busy    <= 1'b1;
					state      <= ST_SEND;
				end else if (test_pending) begin
					tx_start <= 1'b1;
					tx_test  <= 1'b1;
					tx_bytes <= `PKT_BYTES_MIN;
					tx_busy  <= 1'b1;
					state    <= ST_WAIT;
				end
			end
			ST_SEND: begin
				if (f_take && f_valid) begin
					tx_data    <= f_data[31:0];
					tx_valid   <= 1'b1;
					sent_bytes <= sent_bytes + 16'h0004;
					// Short final packet ends on the last flag stored beside its word
					if (f_data[32] || sent_bytes + 16'h0008 > stream_packet_bytes)
						state <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (tx_done && !tx_valid) begin
					gap_count <= 32'h0000_0000;
					state     <= ST_GAP;
				end
			end
			ST_GAP: begin
				if (gap_count >= stream_interpacket_delay) begin
					tx_busy <= 1'b0;
					state   <= ST_IDLE;
				end else if (tick) begin
					gap_count <= gap_count + 32'h0000_0001;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // stream_ctrl

// Synchronous FIFO for stream payload words.
// Assumes one clock; the reader may stall so the writer sees ready fall.
module stream_word_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             sys_clk,
	input  wire             rst_b,
	input  wire             clk_en,
	input  wire [WIDTH-1:0] in_data,
	input  wire             in_valid,
	output wire             in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire             out_valid,
	input  wire             out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wr_ptr;
	reg [AW:0]      rd_ptr;
	wire            full;
	wire            empty;
	wire            do_wr;
	wire            do_rd;

	assign full      = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
	assign empty     = (wr_ptr == rd_ptr);
	assign in_ready  = ~full;
	assign out_valid = ~empty;
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign do_wr     = in_valid & ~full;
	assign do_rd     = out_ready & ~empty;

	always @(posedge sys_clk) begin
		if (clk_en && do_wr)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= {(AW+1){1'b0}};
			rd_ptr <= {(AW+1){1'b0}};
		end else if (clk_en) begin
			if (do_wr)
				wr_ptr <= wr_ptr + 1'b1;
			if (do_rd)
				rd_ptr <= rd_ptr + 1'b1;
		end
	end
endmodule // stream_word_fifo

// ---- verilog/stream_word_fifo.v ----
// Holds no logic: the payload FIFO module sits in stream_ctrl.v beside its only user.
// Assumes nothing; keeping all logic in one design file.
